/* File: core/pis_sched.sv */
// Purpose: runs discovery again and again at random spacing
// Assumes: radio response strobes come from logic on clk_i
// Notes: host talks through a plain register port, events raise irq_o
// Notes on behaviour
// - Spacing runs from one run start to the next, within min and max.
// - Each run draws a fresh random spacing inside the range.
// - Max period is N from 0x03 to 0xFFFF, times 1.28 s.
// - Min period is N from 0x02 to 0xFFFE, times 1.28 s.
// - A run stops when its duration of N x 1.28 s ends, N 0x01..0x30.
// - Limit 0x00 means unlimited; otherwise stop after that many responses.
// - Lower address part 0x9E8B00..0x9E8B3F feeds the access code.
// - Start command 0x0003 completes once the first run has begun.
// - Start and stop return status; zero is success, else an error.
// - Each finished run reports how many devices answered.
// - Each responder raises a result event.
// - Filtered or already reported responders are not reported again; the code only drops a repeat of the last reported address.
// - Stop command 0x0004 halts at once; no runs until restarted.
// - Stop completes after mode ends; a cut run gets no completion.
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
module pis_sched
  import pis_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
)
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  output logic irq_o,
  output logic scan_active_o,
  output logic [23:0] lower_address_part_o,
  input wire logic resp_valid_i,
  input wire logic [ID_W-1:0] resp_addr_i,
  input wire logic resp_filtered_i
);
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  pis_state_t state;
  logic [15:0] max_per;
  logic [15:0] min_per;
  logic [23:0] lower_address_part;
  logic [7:0] run_len;
  logic [7:0] resp_lim;
  logic [15:0] act_max;
  logic [15:0] act_min;
  logic [7:0] act_len;
  logic [7:0] act_lim;
  logic [15:0] period;
  logic period_ok;
  logic [TICK_W-1:0] div_cnt;
  logic tick;
  logic [15:0] per_ticks;
  logic [7:0] run_ticks;
  logic [7:0] resp_cnt;
  logic [7:0] done_cnt;
  logic [ID_W-1:0] last_id;
  logic seen;
  logic [23:0] cmd_res;
  logic [INT_W-1:0] int_stat;
  logic [INT_W-1:0] int_mask;
  logic cmd_we;
  logic [15:0] cmd_code;
  logic params_ok;
  logic start_ok;
  logic stop_ok;
  logic run_start;
  logic report;
  logic run_end;
  logic [7:0] next_resp;
  logic [INT_W-1:0] int_set;

  pis_rand_if rnd ();

  pis_lfsr u_lfsr (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .rnd(rnd)
  );

  assign cmd_we = reg_we_i && hit(reg_addr_i, OFF_CMD);
  assign cmd_code = reg_wdata_i[15:0];

  // Ordering check also bounds min below 0xFFFF and max above min
  always_comb
  begin
    params_ok = (max_per >= MAX_LO) && (min_per >= MIN_LO);
    params_ok = params_ok && (run_len >= LEN_LO) && (run_len <= LEN_HI);
    params_ok = params_ok && (lower_address_part >= LAP_LO) && (lower_address_part <= LAP_HI);
    params_ok = params_ok && (max_per > min_per);
    params_ok = params_ok && (min_per > {8'h00, run_len});
  end

  assign start_ok = cmd_we && (cmd_code == CODE_START) && (state == PIS_IDLE) && params_ok;
  assign stop_ok = cmd_we && (cmd_code == CODE_STOP) && (state != PIS_IDLE);

  assign tick = (state != PIS_IDLE) && (div_cnt == TICK_W'(TICK_CYCLES_P - 1));

  // Next run fires on the tick that closes the drawn spacing
  assign run_start = start_ok || ((state == PIS_WAIT) && tick && period_ok
    && ({1'b0, per_ticks} + 17'h00001 >= {1'b0, period}));

  assign report = (state == PIS_RUN) && resp_valid_i && !resp_filtered_i
    && !(seen && (resp_addr_i == last_id));
  assign next_resp = resp_cnt + (report ? 8'h01 : 8'h00);

  // A run cut by the stop command never reaches run_end
  assign run_end = (state == PIS_RUN) && !stop_ok
    && ((tick && (run_ticks + 8'h01 == act_len))
    || (report && (act_lim != 8'h00) && (next_resp == act_lim)));

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state <= PIS_IDLE;
    end
    else if (stop_ok)
    begin
      state <= PIS_IDLE;
    end
    else if (run_start)
    begin
      state <= PIS_RUN;
    end
    else if (run_end)
    begin
      state <= PIS_WAIT;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      max_per <= MAX_RST;
      min_per <= MIN_RST;
      lower_address_part <= LAP_LO;
      run_len <= LEN_RST;
      resp_lim <= LIM_RST;
    end
    else if (reg_we_i)
    begin
      if (hit(reg_addr_i, OFF_MAX))
        max_per <= reg_wdata_i[15:0];
      if (hit(reg_addr_i, OFF_MIN))
        min_per <= reg_wdata_i[15:0];
      if (hit(reg_addr_i, OFF_LAP))
        lower_address_part <= reg_wdata_i[23:0];
      if (hit(reg_addr_i, OFF_LEN))
        run_len <= reg_wdata_i[7:0];
      if (hit(reg_addr_i, OFF_LIM))
        resp_lim <= reg_wdata_i[7:0];
    end
  end

  // Snapshot keeps a running mode steady while software edits registers
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      act_max <= MAX_RST;
      act_min <= MIN_RST;
      act_len <= LEN_RST;
      act_lim <= LIM_RST;
      lower_address_part_o <= LAP_LO;
    end
    else if (start_ok)
    begin
      act_max <= max_per;
      act_min <= min_per;
      act_len <= run_len;
      act_lim <= resp_lim;
      lower_address_part_o <= lower_address_part;
    end
  end

  // Rejection sampling: the generator walks every value, so a hit comes
  // within 65535 cycles, far shorter than the smallest spacing
  assign rnd.enable = (state != PIS_IDLE) || start_ok;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      period <= 16'h0000;
      period_ok <= 1'b0;
    end
    else if (run_start)
    begin
      period_ok <= 1'b0;
    end
    else if (!period_ok && (state != PIS_IDLE)
      && (rnd.value >= act_min) && (rnd.value <= act_max))
    begin
      period <= rnd.value;
      period_ok <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      div_cnt <= '0;
    end
    else if (run_start || state == PIS_IDLE)
    begin
      div_cnt <= '0;
    end
    else if (tick)
    begin
      div_cnt <= '0;
    end
    else
    begin
      div_cnt <= div_cnt + TICK_W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      per_ticks <= 16'h0000;
      run_ticks <= 8'h00;
    end
    else if (run_start)
    begin
      per_ticks <= 16'h0000;
      run_ticks <= 8'h00;
    end
    else if (tick)
    begin
      per_ticks <= per_ticks + 16'h0001;
      if (state == PIS_RUN)
        run_ticks <= run_ticks + 8'h01;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      resp_cnt <= 8'h00;
      seen <= 1'b0;
      last_id <= '0;
    end
    else if (run_start)
    begin
      resp_cnt <= 8'h00;
      seen <= 1'b0;
    end
    else if (report)
    begin
      resp_cnt <= next_resp;
      seen <= 1'b1;
      last_id <= resp_addr_i;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      done_cnt <= 8'h00;
    end
    else if (run_end)
    begin
      done_cnt <= next_resp;
    end
  end

  // Start completes in the same edge the first run begins
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cmd_res <= 24'h000000;
    end
    else if (cmd_we)
    begin
      if (start_ok || stop_ok)
        cmd_res <= {ST_OK, cmd_code};
      else if (cmd_code == CODE_START && state != PIS_IDLE)
        cmd_res <= {ST_BUSY, cmd_code};
      else if (cmd_code == CODE_START)
        cmd_res <= {ST_BAD_PARAM, cmd_code};
      else if (cmd_code == CODE_STOP)
        cmd_res <= {ST_NOT_ACTIVE, cmd_code};
      else
        cmd_res <= {ST_UNKNOWN, cmd_code};
    end
  end

  always_comb
  begin
    int_set = '0;
    int_set[INT_CMD] = cmd_we;
    int_set[INT_RESULT] = report;
    int_set[INT_RUN] = run_end;
  end

  // Set beats a same-cycle write-one clear so no event is lost
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      int_stat <= '0;
      int_mask <= '0;
    end
    else
    begin
      if (reg_we_i && hit(reg_addr_i, OFF_INT))
        int_stat <= (int_stat & ~reg_wdata_i[INT_W-1:0]) | int_set;
      else
        int_stat <= int_stat | int_set;
      if (reg_we_i && hit(reg_addr_i, OFF_MASK))
        int_mask <= reg_wdata_i[INT_W-1:0];
    end
  end

  assign irq_o = |(int_stat & int_mask);
  assign scan_active_o = (state == PIS_RUN);

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      reg_rdata_o <= '0;
    end
    else if (reg_re_i)
    begin
      reg_rdata_o <= '0;
      if (hit(reg_addr_i, OFF_MAX))
        reg_rdata_o <= {16'h0000, max_per};
      if (hit(reg_addr_i, OFF_MIN))
        reg_rdata_o <= {16'h0000, min_per};
      if (hit(reg_addr_i, OFF_LAP))
        reg_rdata_o <= {8'h00, lower_address_part};
      if (hit(reg_addr_i, OFF_LEN))
        reg_rdata_o <= {24'h000000, run_len};
      if (hit(reg_addr_i, OFF_LIM))
        reg_rdata_o <= {24'h000000, resp_lim};
      if (hit(reg_addr_i, OFF_CRES))
        reg_rdata_o <= {8'h00, cmd_res};
      if (hit(reg_addr_i, OFF_STAT))
        reg_rdata_o <= {22'h0, state == PIS_RUN, state != PIS_IDLE, resp_cnt};
      if (hit(reg_addr_i, OFF_DONE))
        reg_rdata_o <= {24'h000000, done_cnt};
      if (hit(reg_addr_i, OFF_RES))
        reg_rdata_o <= last_id;
      if (hit(reg_addr_i, OFF_INT))
        reg_rdata_o <= {29'h0, int_stat};
      if (hit(reg_addr_i, OFF_MASK))
        reg_rdata_o <= {29'h0, int_mask};
    end
  end
endmodule

/* File: core/pis_pkg.sv */
// Purpose: constants and types for the periodic discovery scheduler
// Assumes: 10 MHz clock, word-spaced register offsets
// Notes: status codes other than success are local choices
package pis_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int ID_W = 32;
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_MAX = 8'h04;
  localparam logic [7:0] OFF_MIN = 8'h08;
  localparam logic [7:0] OFF_LAP = 8'h0C;
  localparam logic [7:0] OFF_LEN = 8'h10;
  localparam logic [7:0] OFF_LIM = 8'h14;
  localparam logic [7:0] OFF_CRES = 8'h18;
  localparam logic [7:0] OFF_STAT = 8'h1C;
  localparam logic [7:0] OFF_DONE = 8'h20;
  localparam logic [7:0] OFF_RES = 8'h24;
  localparam logic [7:0] OFF_INT = 8'h28;
  localparam logic [7:0] OFF_MASK = 8'h2C;
  localparam logic [15:0] CODE_START = 16'h0003;
  localparam logic [15:0] CODE_STOP = 16'h0004;
  localparam logic [15:0] MAX_LO = 16'h0003;
  localparam logic [15:0] MIN_LO = 16'h0002;
  localparam logic [7:0] LEN_LO = 8'h01;
  localparam logic [7:0] LEN_HI = 8'h30;
  localparam logic [23:0] LAP_LO = 24'h9E8B00;
  localparam logic [23:0] LAP_HI = 24'h9E8B3F;
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_UNKNOWN = 8'h01;
  localparam logic [7:0] ST_BUSY = 8'h0C;
  localparam logic [7:0] ST_NOT_ACTIVE = 8'h0D;
  localparam logic [7:0] ST_BAD_PARAM = 8'h12;
  localparam int INT_CMD = 0;
  localparam int INT_RESULT = 1;
  localparam int INT_RUN = 2;
  localparam int INT_W = 3;
  localparam int STAT_MODE = 8;
  localparam int STAT_RUN = 9;
  localparam logic [15:0] MAX_RST = 16'h0004;
  localparam logic [15:0] MIN_RST = 16'h0003;
  localparam logic [7:0] LEN_RST = 8'h01;
  localparam logic [7:0] LIM_RST = 8'h00;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
  localparam logic [15:0] LFSR_TAPS = 16'hB400;
  localparam longint UNIT_NS = 1280000000;
  localparam longint CLK_NS = 100;
  localparam int TICK_W = 24;
  localparam int TICK_CYCLES = int'(UNIT_NS / CLK_NS);
  typedef enum logic [1:0] {PIS_IDLE, PIS_RUN, PIS_WAIT} pis_state_t;
endpackage

/* File: core/pis_rand_if.sv */
// Purpose: carries random words from the generator to the scheduler
// Assumes: both ends on clk_i
// Notes: value moves one step per cycle while enable is high
interface pis_rand_if;
  logic enable;
  logic [15:0] value;
  modport gen (input enable, output value);
  modport user (output enable, input value);
endinterface

/* File: core/pis_lfsr.sv */
// Purpose: 16-bit Galois generator for random run spacing
// Assumes: nonzero seed
// Notes: walks every value 0x0001..0xFFFF once per cycle of the sequence
module pis_lfsr
  import pis_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  pis_rand_if.gen rnd
);
  logic [15:0] state;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state <= LFSR_SEED;
    end
    else if (rnd.enable)
    begin
      state <= {1'b0, state[15:1]} ^ (state[0] ? LFSR_TAPS : 16'h0000);
    end
  end

  assign rnd.value = state;
endmodule

/* File: tb/pis_sched_chk.sv */
// Purpose: port-level timing checks for the scheduler
// Assumes: one clock, async active-low reset
// Notes: spacing is checked as a lower bound, short ticks may delay a run
module pis_sched_chk
  import pis_pkg::*;
#(
  parameter int TICK_CYCLES_P = 8
)
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire logic [DATA_W-1:0] reg_rdata_o,
  input wire logic irq_o,
  input wire logic scan_active_o,
  input wire logic [23:0] lower_address_part_o
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RUN_MAX = 48 * TICK_CYCLES_P + 2;
  localparam int GAP_MIN = 2 * TICK_CYCLES_P - 1;
  logic [7:0] len_q;
  logic scan_q;
  logic armed;
  int run_cnt;
  int gap;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_stop;
    reg_we_i && reg_addr_i == OFF_CMD && reg_wdata_i[15:0] == CODE_STOP;
  endsequence
  sequence s_len_wr;
    reg_we_i && reg_addr_i == OFF_LEN;
  endsequence
  sequence s_len_rd;
    reg_re_i && reg_addr_i == OFF_LEN;
  endsequence
  always_ff @(posedge clk_i)
  begin
    if (reg_we_i && reg_addr_i == OFF_LEN)
      len_q <= reg_wdata_i[7:0];
  end
  // A stop disarms the spacing check, a restart may come at any time
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      scan_q <= 1'b0;
      armed <= 1'b0;
      run_cnt <= 0;
      gap <= 0;
    end
    else
    begin
      scan_q <= scan_active_o;
      run_cnt <= scan_active_o ? run_cnt + 1 : 0;
      gap <= (scan_active_o && !scan_q) ? 0 : gap + 1;
      if (reg_we_i && reg_addr_i == OFF_CMD && reg_wdata_i[15:0] == CODE_STOP)
        armed <= 1'b0;
      else if (scan_active_o && !scan_q)
        armed <= 1'b1;
    end
  end
  chk_stop_halts_run: assert property (s_stop |=> !scan_active_o [*8])
    else $error("run continued after stop");
  chk_unmapped_reads_zero: assert property (reg_re_i && reg_addr_i == 8'h30
    |=> reg_rdata_o == 32'h0)
    else $error("unmapped read not zero");
  chk_mask_quiets_irq: assert property (reg_we_i && reg_addr_i == OFF_MASK
    && reg_wdata_i[2:0] == 3'h0 |=> !irq_o)
    else $error("irq high with all masked");
  chk_run_length_bound: assert property (run_cnt <= RUN_MAX)
    else $error("run longer than longest duration");
  chk_spacing_min_gap: assert property (scan_active_o && !scan_q && armed
    |-> gap >= GAP_MIN)
    else $error("runs started too close");
  chk_lap_in_range: assert property (lower_address_part_o >= LAP_LO
    && lower_address_part_o <= LAP_HI)
    else $error("address part out of range");
  chk_lap_held_run: assert property (scan_active_o && $past(scan_active_o)
    |-> $stable(lower_address_part_o))
    else $error("address part changed in run");
  chk_len_read_back: assert property (s_len_wr ##[1:2] s_len_rd
    |=> reg_rdata_o == {24'h0, len_q})
    else $error("duration read back wrong");
endmodule
bind pis_sched pis_sched_chk #(.TICK_CYCLES_P(TICK_CYCLES_P)) chk_u (
  .clk_i(clk_i),
  .resetn_i(resetn_i),
  .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i),
  .reg_we_i(reg_we_i),
  .reg_re_i(reg_re_i),
  .reg_rdata_o(reg_rdata_o),
  .irq_o(irq_o),
  .scan_active_o(scan_active_o),
  .lower_address_part_o(lower_address_part_o)
);

/* File: tb/pis_radio_model.sv */
// Purpose: remote devices answering a discovery run
// Assumes: fire_i is a one-cycle request from the bench
// Notes: idle id lines toggle so a stale id never looks fresh
module pis_radio_model
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic scan_i,
  input wire logic fire_i,
  input wire logic [31:0] id_i,
  input wire logic filt_i,
  output logic valid_o,
  output logic [31:0] id_o,
  output logic filt_o
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      valid_o <= 1'b0;
      id_o <= 32'h0;
      filt_o <= 1'b0;
    end
    else if (fire_i && scan_i)
    begin
      valid_o <= 1'b1;
      id_o <= id_i;
      filt_o <= filt_i;
    end
    else
    begin
      valid_o <= 1'b0;
      id_o <= ~id_o;
      filt_o <= ~filt_o;
    end
  end
endmodule

/* File: tb/periodic_inquiry_scheduler_tb.sv */
// Purpose: self-checking bench for the scheduler
// Assumes: ticks of 8 cycles so runs fit the time budget
// Notes: short ticks may delay a run, so spacing is a lower bound
module periodic_inquiry_scheduler_tb
  import pis_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int T = 8;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} pis_row_t;
  pis_row_t rows [6] = '{'{OFF_MAX, 32'h6, 32'h6}, '{OFF_MIN, 32'h4, 32'h4},
    '{OFF_LAP, 32'h9E8B3F, 32'h9E8B3F}, '{OFF_LEN, 32'hFFFFFF03, 32'h3},
    '{OFF_MASK, 32'h7, 32'h7}, '{8'h30, 32'hAA, 32'h0}};
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_we_i = 1'b0;
  logic reg_re_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic irq_o;
  logic scan_active_o;
  logic [23:0] lower_address_part_o;
  logic resp_valid_i;
  logic [31:0] resp_addr_i;
  logic resp_filtered_i;
  logic fire = 1'b0;
  logic [31:0] fire_id = 32'h0;
  logic fire_filt = 1'b0;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  int t0;
  pis_sched #(.TICK_CYCLES_P(T)) dut_u (.clk_i(clk_i), .resetn_i(resetn_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
    .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o),
    .scan_active_o(scan_active_o), .lower_address_part_o(lower_address_part_o),
    .resp_valid_i(resp_valid_i), .resp_addr_i(resp_addr_i),
    .resp_filtered_i(resp_filtered_i));
  pis_radio_model radio_u (.clk_i(clk_i), .resetn_i(resetn_i), .scan_i(scan_active_o),
    .fire_i(fire), .id_i(fire_id), .filt_i(fire_filt), .valid_o(resp_valid_i),
    .id_o(resp_addr_i), .filt_o(resp_filtered_i));
  always #50 clk_i = ~clk_i;
  task automatic close_out();
    $display("mismatches %0d tests %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Ceiling covers a worst-case spacing draw of 65535 cycles
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 95000)
    begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_we_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    reg_re_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    @(negedge clk_i);
    chk(reg_rdata_o, e);
  endtask
  task automatic fire_one(input logic [31:0] id, input logic f);
    @(posedge clk_i);
    fire <= 1'b1;
    fire_id <= id;
    fire_filt <= f;
    @(posedge clk_i);
    fire <= 1'b0;
  endtask
  task automatic wait_scan(input logic v);
    int n;
    n = 0;
    while (scan_active_o !== v && n < 70000)
    begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 70000)
    begin
      n_mismatch++;
      $display("ERROR %0t wait for run state ran out", $time);
      close_out();
    end
  endtask
  initial
  begin
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    rd(OFF_MAX, 32'h4);
    rd(OFF_LAP, 32'h9E8B00);
    rd(OFF_LIM, 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    wr(OFF_CMD, 32'h3);
    t0 = cyc;
    fire_one(32'h11, 1'b0);
    fire_one(32'h11, 1'b0);
    fire_one(32'h22, 1'b1);
    fire_one(32'h33, 1'b0);
    rd(OFF_STAT, 32'h302);
    rd(OFF_RES, 32'h33);
    rd(OFF_CRES, 32'h3);
    chk(32'(lower_address_part_o), 32'h9E8B3F);
    wait_scan(1'b0);
    rd(OFF_DONE, 32'h2);
    rd(OFF_INT, 32'h7);
    wr(OFF_INT, 32'h7);
    rd(OFF_INT, 32'h0);
    wait_scan(1'b1);
    chk(32'(cyc - t0 >= 4 * T - 2), 32'h1);
    wr(OFF_CMD, 32'h4);
    @(negedge clk_i);
    chk(32'(scan_active_o), 32'h0);
    repeat (40) @(negedge clk_i);
    chk(32'(scan_active_o), 32'h0);
    rd(OFF_INT, 32'h1);
    rd(OFF_CRES, 32'h4);
    wr(OFF_CMD, 32'h4);
    rd(OFF_CRES, 32'h0D0004);
    wr(OFF_CMD, 32'h5);
    rd(OFF_CRES, 32'h010005);
    wr(OFF_LEN, 32'h31);
    wr(OFF_CMD, 32'h3);
    rd(OFF_CRES, 32'h120003);
    chk(32'(scan_active_o), 32'h0);
    wr(OFF_LEN, 32'h2);
    wr(OFF_LIM, 32'h1);
    wr(OFF_CMD, 32'h3);
    wr(OFF_CMD, 32'h3);
    rd(OFF_CRES, 32'h0C0003);
    fire_one(32'h44, 1'b0);
    repeat (3) @(negedge clk_i);
    chk(32'(scan_active_o), 32'h0);
    rd(OFF_DONE, 32'h1);
    chk(32'(irq_o), 32'h1);
    wr(OFF_MASK, 32'h0);
    @(negedge clk_i);
    chk(32'(irq_o), 32'h0);
    // Reset while the mode waits for its next run must drop the mode
    @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(negedge clk_i);
    chk(32'(scan_active_o), 32'h0);
    chk(32'(lower_address_part_o), 32'h9E8B00);
    rd(OFF_STAT, 32'h0);
    rd(OFF_MAX, 32'h4);
    repeat (40) @(negedge clk_i);
    chk(32'(scan_active_o), 32'h0);
    wr(OFF_CMD, 32'h4);
    rd(OFF_CRES, 32'h0D0004);
    close_out();
  end
endmodule
